/* File: hdl/mdud_div.sv */
// division path of the multiply/divide unit: registers, sequencer, results
`timescale 1ns/1ps
`default_nettype none
module mdud_div (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // cpu register port
  input wire logic wr_en,
  input wire logic [2:0] wr_sel,
  input wire logic [15:0] wr_data,
  input wire logic [2:0] rd_sel,
  output logic [15:0] rd_data,
  // status
  output logic divide_done_irq,
  output logic busy
);
  logic [7:0] muldiv_control_r;
  logic [15:0] operand_a_high_r;
  logic [15:0] operand_a_low_r;
  logic [15:0] operand_b_high_r;
  logic [15:0] operand_b_low_r;
  logic [15:0] result_c_high_r;
  logic [15:0] result_c_low_r;
  logic [4:0] cnt_r;
  logic [4:0] cnt_nxt;
  mdud_pkg::mdud_state_t state_r;
  logic start_req;
  logic finish;
  logic [15:0] rd_nxt;
  mdud_step_if st ();

  mdud_step #(.BITS(mdud_pkg::BITS_PER_CLK)) u_step (.s(st));

  // a start is a write of the start bit with division selected in the same byte
  assign start_req = wr_en && (wr_sel == mdud_pkg::SEL_CTRL)
    && wr_data[mdud_pkg::DIV_START_BIT] && wr_data[mdud_pkg::DIV_SEL_BIT];
  assign finish = (state_r == mdud_pkg::MDUD_RUN) && (cnt_r == mdud_pkg::CNT_LAST - 5'h01);
  assign cnt_nxt = cnt_r + 5'h01;

  // step operands: dividend shifts out of A, partial remainder lives in C
  assign st.rem_in = {result_c_high_r, result_c_low_r};
  assign st.quo_in = {operand_a_high_r, operand_a_low_r};
  assign st.divisor = {operand_b_high_r, operand_b_low_r};

  // sequencer state
  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= mdud_pkg::MDUD_IDLE;
    end else begin
      unique case (state_r)
        mdud_pkg::MDUD_IDLE: begin
          if (start_req) begin
            state_r <= mdud_pkg::MDUD_RUN;
          end
        end
        mdud_pkg::MDUD_RUN: begin
          if (finish) begin
            state_r <= mdud_pkg::MDUD_IDLE;
          end
        end
        default: state_r <= mdud_pkg::MDUD_IDLE;
      endcase
    end
  end

  // clock counter for the fixed-length operation
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_r <= '0;
    end else if (state_r == mdud_pkg::MDUD_RUN) begin
      cnt_r <= cnt_nxt;
    end else begin
      cnt_r <= '0;
    end
  end

  // control register; start bit clears by hardware at the end
  always_ff @(posedge clk) begin
    if (rst) begin
      muldiv_control_r <= mdud_pkg::CTRL_RESET;
    end else if (finish) begin
      muldiv_control_r[mdud_pkg::DIV_START_BIT] <= 1'b0;
    end else if (wr_en && wr_sel == mdud_pkg::SEL_CTRL && state_r == mdud_pkg::MDUD_IDLE) begin
      muldiv_control_r <= wr_data[7:0];
      muldiv_control_r[mdud_pkg::DIV_START_BIT] <= start_req;
    end
  end

  // operand A: loaded by cpu, then becomes the quotient
  always_ff @(posedge clk) begin
    if (rst) begin
      operand_a_high_r <= mdud_pkg::HALF_RESET;
      operand_a_low_r <= mdud_pkg::HALF_RESET;
    end else if (state_r == mdud_pkg::MDUD_RUN) begin
      operand_a_high_r <= st.quo_out[31:16];
      operand_a_low_r <= st.quo_out[15:0];
    end else if (wr_en && wr_sel == mdud_pkg::SEL_A_HIGH) begin
      operand_a_high_r <= wr_data;
    end else if (wr_en && wr_sel == mdud_pkg::SEL_A_LOW) begin
      operand_a_low_r <= wr_data;
    end
  end

  // operand B: divisor, held through the operation
  always_ff @(posedge clk) begin
    if (rst) begin
      operand_b_high_r <= mdud_pkg::HALF_RESET;
      operand_b_low_r <= mdud_pkg::HALF_RESET;
    end else if (wr_en && state_r == mdud_pkg::MDUD_IDLE) begin
      if (wr_sel == mdud_pkg::SEL_B_HIGH) begin
        operand_b_high_r <= wr_data;
      end
      if (wr_sel == mdud_pkg::SEL_B_LOW) begin
        operand_b_low_r <= wr_data;
      end
    end
  end

  // result C: cleared on start, partial remainder, final remainder
  always_ff @(posedge clk) begin
    if (rst) begin
      result_c_high_r <= mdud_pkg::HALF_RESET;
      result_c_low_r <= mdud_pkg::HALF_RESET;
    end else if (state_r == mdud_pkg::MDUD_RUN) begin
      result_c_high_r <= st.rem_out[31:16];
      result_c_low_r <= st.rem_out[15:0];
    end else if (start_req) begin
      result_c_high_r <= mdud_pkg::HALF_RESET;
      result_c_low_r <= mdud_pkg::HALF_RESET;
    end else if (wr_en && wr_sel == mdud_pkg::SEL_C_HIGH) begin
      result_c_high_r <= wr_data;
    end else if (wr_en && wr_sel == mdud_pkg::SEL_C_LOW) begin
      result_c_low_r <= wr_data;
    end
  end

  // read mux; intermediate values show during operation and are not meaningful
  always_comb begin
    unique case (rd_sel)
      mdud_pkg::SEL_CTRL: rd_nxt = {8'h00, muldiv_control_r};
      mdud_pkg::SEL_A_HIGH: rd_nxt = operand_a_high_r;
      mdud_pkg::SEL_A_LOW: rd_nxt = operand_a_low_r;
      mdud_pkg::SEL_B_HIGH: rd_nxt = operand_b_high_r;
      mdud_pkg::SEL_B_LOW: rd_nxt = operand_b_low_r;
      mdud_pkg::SEL_C_HIGH: rd_nxt = result_c_high_r;
      mdud_pkg::SEL_C_LOW: rd_nxt = result_c_low_r;
      default: rd_nxt = 16'h0000;
    endcase
  end

  // registered outputs
  always_ff @(posedge clk) begin
    if (rst) begin
      rd_data <= 16'h0000;
      divide_done_irq <= 1'b0;
      busy <= 1'b0;
    end else begin
      rd_data <= rd_nxt;
      divide_done_irq <= finish;
      busy <= (state_r == mdud_pkg::MDUD_RUN) && !finish;
    end
  end

  // checks
  logic [31:0] dvd_q;
  logic [31:0] dvs_q;
  always_ff @(posedge clk) begin
    if (start_req && state_r == mdud_pkg::MDUD_IDLE) begin
      dvd_q <= {operand_a_high_r, operand_a_low_r};
      dvs_q <= {operand_b_high_r, operand_b_low_r};
    end
  end

  // running-cycle tally for the length checks, cleared whenever the unit is idle
  logic [4:0] run_cyc_r;
  always_ff @(posedge clk) begin
    if (rst || state_r != mdud_pkg::MDUD_RUN) begin
      run_cyc_r <= 5'h00;
    end else begin
      run_cyc_r <= run_cyc_r + 5'h01;
    end
  end

  start_run_a: assert property (@(posedge clk) disable iff (rst)
    (start_req && state_r == mdud_pkg::MDUD_IDLE) |=> state_r == mdud_pkg::MDUD_RUN)
    else $error("start did not begin division");
  run_len_a: assert property (@(posedge clk) disable iff (rst)
    (state_r == mdud_pkg::MDUD_RUN && run_cyc_r != mdud_pkg::CNT_LAST - 5'h01)
    |=> state_r == mdud_pkg::MDUD_RUN)
    else $error("division ended before 16 clocks");
  run_end_a: assert property (@(posedge clk) disable iff (rst)
    (state_r == mdud_pkg::MDUD_RUN && run_cyc_r == mdud_pkg::CNT_LAST - 5'h01)
    |=> state_r == mdud_pkg::MDUD_IDLE)
    else $error("division ran past 16 clocks");
  done_clear_a: assert property (@(posedge clk) disable iff (rst)
    divide_done_irq |-> !muldiv_control_r[mdud_pkg::DIV_START_BIT] && $fell(busy))
    else $error("interrupt not aligned with start bit clear");
  start_bit_a: assert property (@(posedge clk) disable iff (rst)
    (state_r == mdud_pkg::MDUD_RUN) |-> muldiv_control_r[mdud_pkg::DIV_START_BIT])
    else $error("start bit dropped during operation");
  irq_pulse_a: assert property (@(posedge clk) disable iff (rst)
    divide_done_irq |=> !divide_done_irq)
    else $error("interrupt wider than one cycle");
  quotient_a: assert property (@(posedge clk) disable iff (rst)
    (divide_done_irq && dvs_q != 32'h00000000)
    |-> {operand_a_high_r, operand_a_low_r} == dvd_q / dvs_q)
    else $error("quotient wrong");
  remainder_a: assert property (@(posedge clk) disable iff (rst)
    (divide_done_irq && dvs_q != 32'h00000000)
    |-> {result_c_high_r, result_c_low_r} == dvd_q % dvs_q)
    else $error("remainder wrong");
  divisor_hold_a: assert property (@(posedge clk) disable iff (rst)
    (state_r == mdud_pkg::MDUD_RUN) |-> {operand_b_high_r, operand_b_low_r} == dvs_q)
    else $error("divisor changed during operation");
  mode_sel_a: assert property (@(posedge clk) disable iff (rst)
    (state_r == mdud_pkg::MDUD_RUN) |-> muldiv_control_r[mdud_pkg::DIV_SEL_BIT])
    else $error("running without division mode");
  start_c: cover property (@(posedge clk) disable iff (rst) start_req);
  done_c: cover property (@(posedge clk) disable iff (rst) divide_done_irq);
  zero_div_c: cover property (@(posedge clk) disable iff (rst)
    divide_done_irq && dvs_q == 32'h00000000);
endmodule : mdud_div
`default_nettype wire

/* File: hdl/mdud_pkg.sv */
// constants for the divide path of the multiply/divide unit
package mdud_pkg;
  localparam int unsigned HALF_W = 16;
  localparam int unsigned WORD_W = 32;
  localparam int unsigned CTRL_W = 8;
  // control register field positions
  localparam int unsigned DIV_SEL_BIT = 7;
  localparam int unsigned DIV_START_BIT = 0;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [15:0] HALF_RESET = 16'h0000;
  // operation length in clocks
  localparam int unsigned DIV_CLOCKS = 16;
  localparam int unsigned BITS_PER_CLK = WORD_W / DIV_CLOCKS;
  localparam int unsigned CNT_W = 5;
  localparam logic [4:0] CNT_LAST = 5'h10;
  // register select codes on the cpu write port
  localparam logic [2:0] SEL_CTRL = 3'h0;
  localparam logic [2:0] SEL_A_HIGH = 3'h1;
  localparam logic [2:0] SEL_A_LOW = 3'h2;
  localparam logic [2:0] SEL_B_HIGH = 3'h3;
  localparam logic [2:0] SEL_B_LOW = 3'h4;
  localparam logic [2:0] SEL_C_HIGH = 3'h5;
  localparam logic [2:0] SEL_C_LOW = 3'h6;
  // divider states, one-hot
  typedef enum logic [1:0] {
    MDUD_IDLE = 2'b01,
    MDUD_RUN = 2'b10
  } mdud_state_t;
endpackage : mdud_pkg

/* File: hdl/mdud_step.sv */
// combinational restoring divide step, several quotient bits per clock
`timescale 1ns/1ps
`default_nettype none
module mdud_step #(
  parameter int unsigned BITS = mdud_pkg::BITS_PER_CLK
) (
  mdud_step_if.step s
);
  logic [31:0] r [0:BITS];
  logic [31:0] q [0:BITS];
  assign r[0] = s.rem_in;
  assign q[0] = s.quo_in;
  // unsigned shift-subtract, one stage per quotient bit
  genvar i;
  generate
    for (i = 0; i < BITS; i++) begin : g_bit
      logic [32:0] trial;
      logic [32:0] diff;
      assign trial = {r[i], q[i][31]};
      assign diff = trial - {1'b0, s.divisor};
      assign r[i+1] = diff[32] ? trial[31:0] : diff[31:0];
      assign q[i+1] = {q[i][30:0], ~diff[32]};
    end
  endgenerate
  assign s.rem_out = r[BITS];
  assign s.quo_out = q[BITS];
endmodule : mdud_step
`default_nettype wire

/* File: hdl/mdud_step_if.sv */
// carrier between the sequencer and the restoring divide step
`timescale 1ns/1ps
`default_nettype none
interface mdud_step_if;
  logic [31:0] rem_in;
  logic [31:0] quo_in;
  logic [31:0] divisor;
  logic [31:0] rem_out;
  logic [31:0] quo_out;
  modport seq (output rem_in, output quo_in, output divisor, input rem_out, input quo_out);
  modport step (input rem_in, input quo_in, input divisor, output rem_out, output quo_out);
endinterface : mdud_step_if
`default_nettype wire

/* File: sim/tb_top.sv */
// self-checking bench for the divide path of the multiply/divide unit
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin mismatches++; \
  $display("BAD %s exp %h got %h", nm, ex, got); end end
module tb_top;
  typedef struct {logic [31:0] a; logic [31:0] b; bit rev;
    logic [31:0] q; logic [31:0] r;} mdud_tb_row_t;
  logic clk;
  logic rst;
  logic wr_en;
  logic [2:0] wr_sel;
  logic [15:0] wr_data;
  logic [2:0] rd_sel;
  logic [15:0] rd_data;
  logic divide_done_irq;
  logic busy;
  int mismatches = 0;
  int num_checks = 0;
  int cycles = 0;
  int irqs;
  // ordinary cases: dividend, divisor, load order reversed or not, quotient, remainder
  mdud_tb_row_t rows [7] = '{
    '{32'h0000_0064, 32'h0000_0007, 1'b0, 32'h0000_000e, 32'h0000_0002},
    '{32'hffff_ffff, 32'h0000_0001, 1'b1, 32'hffff_ffff, 32'h0000_0000},
    '{32'h1234_5678, 32'h0000_abcd, 1'b0, 32'h0000_1b20, 32'h0000_3dd8},
    '{32'h0000_0005, 32'h0000_0009, 1'b1, 32'h0000_0000, 32'h0000_0005},
    '{32'h8000_0000, 32'h0000_0003, 1'b0, 32'h2aaa_aaaa, 32'h0000_0002},
    '{32'hffff_fffe, 32'hffff_ffff, 1'b1, 32'h0000_0000, 32'hffff_fffe},
    '{32'hdead_beef, 32'h0001_0000, 1'b0, 32'h0000_dead, 32'h0000_beef}};

  mdud_div dut_u (
    .clk(clk),
    .rst(rst),
    .wr_en(wr_en),
    .wr_sel(wr_sel),
    .wr_data(wr_data),
    .rd_sel(rd_sel),
    .rd_data(rd_data),
    .divide_done_irq(divide_done_irq),
    .busy(busy)
  );

  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // cuts a hung run short
  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      mismatches++;
      results();
    end
  end

  // verdict and end of run
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : results

  // one write, strobe left up for a following write
  task automatic wr(input logic [2:0] s, input logic [15:0] d);
    wr_en <= 1'b1;
    wr_sel <= s;
    wr_data <= d;
    @(posedge clk);
  endtask : wr

  // registered read, sampled mid-cycle
  task automatic rd(input logic [2:0] s, output logic [15:0] v);
    @(posedge clk);
    rd_sel <= s;
    @(posedge clk);
    @(negedge clk);
    v = rd_data;
  endtask : rd

  // operand halves back to back, then select plus start in the next cycle
  task automatic load(input logic [31:0] a, input logic [31:0] b, input bit rev);
    logic [15:0] h [4];
    logic [2:0] s [4];
    int k;
    h = '{a[31:16], a[15:0], b[31:16], b[15:0]};
    s = '{mdud_pkg::SEL_A_HIGH, mdud_pkg::SEL_A_LOW, mdud_pkg::SEL_B_HIGH, mdud_pkg::SEL_B_LOW};
    @(posedge clk);
    for (int i = 0; i < 4; i++) begin
      k = rev ? 3 - i : i;
      wr(s[k], h[k]);
    end
    wr(mdud_pkg::SEL_CTRL, 16'h0081);
    wr_en <= 1'b0;
    rd_sel <= mdud_pkg::SEL_CTRL; // poll control only, b and c unread while running
  endtask : load

  // full division with timing, polling and result checks
  task automatic run_div(input logic [31:0] a, input logic [31:0] b, input bit rev,
                         input logic [31:0] q, input logic [31:0] r);
    logic [15:0] qh, ql, rh, rl, bl;
    int n;
    load(a, b, rev);
    n = 0;
    while (n < 40 && divide_done_irq !== 1'b1) begin
      @(posedge clk);
      n++;
      @(negedge clk);
      if (n == 8) begin
        `CHK("busy mid run", 1'b1, busy)
        `CHK("start bit mid run", 1'b1, rd_data[0])
      end
    end
    `CHK("cycles to done", 16, n)
    `CHK("busy at done", 1'b0, busy)
    @(negedge clk);
    `CHK("start bit at done", 1'b0, rd_data[0])
    `CHK("irq one cycle", 1'b0, divide_done_irq)
    rd(mdud_pkg::SEL_C_HIGH, rh);
    rd(mdud_pkg::SEL_A_LOW, ql);
    rd(mdud_pkg::SEL_C_LOW, rl);
    rd(mdud_pkg::SEL_A_HIGH, qh);
    rd(mdud_pkg::SEL_B_LOW, bl);
    `CHK("divisor low held", b[15:0], bl)
    `CHK("quotient", q, {qh, ql})
    `CHK("remainder", r, {rh, rl})
  endtask : run_div

  initial begin
    logic [15:0] v;
    rst <= 1'b1;
    wr_en <= 1'b0;
    wr_sel <= 3'h0;
    wr_data <= 16'h0000;
    rd_sel <= 3'h0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    `CHK("reset busy", 1'b0, busy)
    `CHK("reset irq", 1'b0, divide_done_irq)
    `CHK("reset rd_data", 16'h0000, rd_data)
    $display("test reset done");
    foreach (rows[i]) begin
      run_div(rows[i].a, rows[i].b, rows[i].rev, rows[i].q, rows[i].r);
      $display("test row %0d done", i);
    end
    // start without the mode bit is ignored
    @(posedge clk);
    wr(mdud_pkg::SEL_CTRL, 16'h0001);
    wr_en <= 1'b0;
    repeat (4) @(negedge clk);
    `CHK("start no mode busy", 1'b0, busy)
    rd(mdud_pkg::SEL_CTRL, v);
    `CHK("start no mode bit", 1'b0, v[0])
    $display("test no mode done");
    // divide by zero
    run_div(32'h1234_5678, 32'h0000_0000, 1'b1, 32'hffff_ffff, 32'h1234_5678);
    $display("test zero divisor done");
    // reset in mid run abandons the operation
    load(32'h0000_1000, 32'h0000_0010, 1'b0);
    repeat (5) @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    irqs = 0;
    repeat (20) begin
      @(negedge clk);
      if (divide_done_irq === 1'b1) irqs++;
    end
    `CHK("mid reset busy", 1'b0, busy)
    `CHK("mid reset irq", 0, irqs)
    run_div(32'h0000_1000, 32'h0000_0010, 1'b1, 32'h0000_0100, 32'h0000_0000);
    $display("test mid reset done");
    results();
  end
endmodule : tb_top
`undef CHK
`default_nettype wire
